//--- core/supervisor_flags_pkg.sv
// Constants for the supervisor status and event-flag register group.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
// Behaviour
// - Monitor B good event latches bit 4.
// - Monitor A good event latches bit 2.
// - Analog supply good event latches bit 0.
// - Sync clock invalid reads 1 at bit 3.
// - Thermal shutdown live at bit 2.
// - Thermal warning live at bit 1.
// - Input overvoltage live at bit 0.
// - Step-down B enabled at bit 7.
// - Step-down B power good at bit 6.
// - Step-down B current limit at bit 4.
// - Step-down A enabled at bit 3.
// - Step-down A power good at bit 2.
// - Step-down A current limit at bit 0.
// - Step-up enabled at bit 3.
// - Step-up power good at bit 2.
// - Step-up current limit at bit 0.
package supervisor_flags_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_MONITOR_EVENT = 8'h24;
	localparam logic [7:0] IDX_CHIP_COND = 8'h25;
	localparam logic [7:0] IDX_STEP_DOWN = 8'h26;
	localparam logic [7:0] IDX_STEP_UP = 8'h27;
	localparam logic [7:0] IDX_EVENT_MASK = 8'h2b;
	localparam int ADDR_LSB = 2;
	localparam int IDX_W = 8;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int EV_MON_B = 4;
	localparam int EV_MON_A = 2;
	localparam int EV_ANALOG = 0;
	localparam int CC_SYNC_BAD = 3;
	localparam int CC_TSD = 2;
	localparam int CC_TWARN = 1;
	localparam int CC_OVP = 0;
	localparam int SD_B_EN = 7;
	localparam int SD_B_GOOD = 6;
	localparam int SD_B_LIM = 4;
	localparam int SD_A_EN = 3;
	localparam int SD_A_GOOD = 2;
	localparam int SD_A_LIM = 0;
	localparam int SU_EN = 3;
	localparam int SU_GOOD = 2;
	localparam int SU_LIM = 0;

	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] EVENT_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] EVENT_BITS = 8'h15;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

//--- core/event_flag_bit.sv
// One sticky event flag with write-one-to-clear.
// Assumes event pulses and clear strobes synchronous to clk_i.
module event_flag_bit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic event_i,
	input wire logic clear_i,
	output logic flag_o
);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (event_i) begin
			flag_o <= 1'b1;
		end else if (clear_i) begin
			flag_o <= 1'b0;
		end
	end

endmodule

//--- core/supervisor_status_flags.sv
// Status and event-flag register group of a power supervisor.
// Assumes a classic Wishbone master on clk_i and synchronous live inputs.
module supervisor_status_flags (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	input wire logic monitor_b_good_event_i,
	input wire logic monitor_a_good_event_i,
	input wire logic analog_supply_good_event_i,
	input wire logic sync_clock_valid_i,
	input wire logic thermal_shutdown_live_i,
	input wire logic thermal_warning_live_i,
	input wire logic input_overvoltage_live_i,
	input wire logic step_down_b_enabled_i,
	input wire logic step_down_b_good_live_i,
	input wire logic step_down_b_limit_live_i,
	input wire logic step_down_a_enabled_i,
	input wire logic step_down_a_good_live_i,
	input wire logic step_down_a_limit_live_i,
	input wire logic step_up_enabled_i,
	input wire logic step_up_good_live_i,
	input wire logic step_up_limit_live_i,
	output logic irq_o
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic req;
	logic [7:0] idx;
	logic hit;
	logic wr_lane0;
	logic [7:0] event_reg;
	logic [7:0] mask_reg;
	logic [7:0] event_raw;
	logic [7:0] clear_strobe;
	logic [7:0] chip_cond;
	logic [7:0] step_down;
	logic [7:0] step_up;
	logic [31:0] rdata_next;

	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign idx = adr_i[supervisor_flags_pkg::ADDR_LSB +: supervisor_flags_pkg::IDX_W];
	assign hit = (idx == supervisor_flags_pkg::IDX_MONITOR_EVENT)
		|| (idx == supervisor_flags_pkg::IDX_CHIP_COND)
		|| (idx == supervisor_flags_pkg::IDX_STEP_DOWN)
		|| (idx == supervisor_flags_pkg::IDX_STEP_UP)
		|| (idx == supervisor_flags_pkg::IDX_EVENT_MASK);
	assign wr_lane0 = req && hit && we_i && sel_i[0];

	// ----------------------------------------
	// Sticky event flags
	// ----------------------------------------
	always_comb begin
		event_raw = 8'h00;
		event_raw[supervisor_flags_pkg::EV_MON_B] = monitor_b_good_event_i;
		event_raw[supervisor_flags_pkg::EV_MON_A] = monitor_a_good_event_i;
		event_raw[supervisor_flags_pkg::EV_ANALOG] = analog_supply_good_event_i;
	end

	assign clear_strobe = (wr_lane0 && idx == supervisor_flags_pkg::IDX_MONITOR_EVENT)
		? dat_i[7:0] : 8'h00;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_flag
			if (supervisor_flags_pkg::EVENT_BITS[g]) begin : g_used
				event_flag_bit u_flag (
					.clk_i(clk_i),
					.rst_i(rst_i),
					.event_i(event_raw[g]),
					.clear_i(clear_strobe[g]),
					.flag_o(event_reg[g])
				);
			end else begin : g_unused
				assign event_reg[g] = 1'b0;
			end
		end
	endgenerate

	// ----------------------------------------
	// Interrupt mask
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_reg <= supervisor_flags_pkg::MASK_RESET;
		end else if (wr_lane0 && idx == supervisor_flags_pkg::IDX_EVENT_MASK) begin
			mask_reg <= dat_i[7:0] & supervisor_flags_pkg::EVENT_BITS;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(event_reg & ~mask_reg);
		end
	end

	// ----------------------------------------
	// Live status assembly
	// ----------------------------------------
	always_comb begin
		chip_cond = 8'h00;
		chip_cond[supervisor_flags_pkg::CC_SYNC_BAD] = !sync_clock_valid_i;
		chip_cond[supervisor_flags_pkg::CC_TSD] = thermal_shutdown_live_i;
		chip_cond[supervisor_flags_pkg::CC_TWARN] = thermal_warning_live_i;
		chip_cond[supervisor_flags_pkg::CC_OVP] = input_overvoltage_live_i;
	end

	always_comb begin
		step_down = 8'h00;
		step_down[supervisor_flags_pkg::SD_B_EN] = step_down_b_enabled_i;
		step_down[supervisor_flags_pkg::SD_B_GOOD] = step_down_b_good_live_i;
		step_down[supervisor_flags_pkg::SD_B_LIM] = step_down_b_limit_live_i;
		step_down[supervisor_flags_pkg::SD_A_EN] = step_down_a_enabled_i;
		step_down[supervisor_flags_pkg::SD_A_GOOD] = step_down_a_good_live_i;
		step_down[supervisor_flags_pkg::SD_A_LIM] = step_down_a_limit_live_i;
	end

	always_comb begin
		step_up = 8'h00;
		step_up[supervisor_flags_pkg::SU_EN] = step_up_enabled_i;
		step_up[supervisor_flags_pkg::SU_GOOD] = step_up_good_live_i;
		step_up[supervisor_flags_pkg::SU_LIM] = step_up_limit_live_i;
	end

	// ----------------------------------------
	// Read mux and acknowledge
	// ----------------------------------------
	always_comb begin
		rdata_next = supervisor_flags_pkg::READ_ZERO;
		case (idx)
			supervisor_flags_pkg::IDX_MONITOR_EVENT: rdata_next[7:0] = event_reg;
			supervisor_flags_pkg::IDX_CHIP_COND: rdata_next[7:0] = chip_cond;
			supervisor_flags_pkg::IDX_STEP_DOWN: rdata_next[7:0] = step_down;
			supervisor_flags_pkg::IDX_STEP_UP: rdata_next[7:0] = step_up;
			supervisor_flags_pkg::IDX_EVENT_MASK: rdata_next[7:0] = mask_reg;
			default: rdata_next = supervisor_flags_pkg::READ_ZERO;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= req && hit;
			err_o <= req && !hit;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= supervisor_flags_pkg::READ_ZERO;
		end else if (req && !we_i) begin
			dat_o <= rdata_next;
		end
	end

endmodule

//--- verification/supervisor_flags_sva.sv
// Bus and reserved-bit checks for the supervisor flag register group.
// Assumes binding to supervisor_status_flags on its single clock.
module supervisor_flags_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic err_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req, rd, mapped;
	assign req = cyc_i && stb_i && !ack_o && !err_o;
	assign rd = ack_o && !we_i;
	assign mapped = adr_i[9:2] inside {8'h24, 8'h25, 8'h26, 8'h27, 8'h2b};
	property p_ack; req && mapped |=> ack_o && !err_o; endproperty
	a_ack: assert property (p_ack) else $error("mapped request not acked");
	property p_err; req && !mapped |=> err_o && !ack_o; endproperty
	a_err: assert property (p_err) else $error("unmapped request not refused");
	property p_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
	a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
	property p_hi; ack_o |-> dat_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("upper read bits not zero");
	property p_rst; disable iff (1'b0) rst_i |=> !ack_o && !err_o && !irq_o && dat_o == 32'h0; endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_ev; rd && adr_i[9:2] == 8'h24 |-> (dat_o[7:0] & 8'hea) == 8'h00; endproperty
	a_ev: assert property (p_ev) else $error("event reserved bits set");
	property p_sd; rd && adr_i[9:2] == 8'h26 |-> !dat_o[5] && !dat_o[1]; endproperty
	a_sd: assert property (p_sd) else $error("step-down reserved bits set");
	property p_up; rd && adr_i[9:2] == 8'h27 |-> dat_o[7:4] == 4'h0 && !dat_o[1]; endproperty
	a_up: assert property (p_up) else $error("step-up reserved bits set");
endmodule
bind supervisor_status_flags supervisor_flags_sva chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
	.ack_o(ack_o), .err_o(err_o), .irq_o(irq_o));

//--- verification/tb.sv
// Self-checking bench for the supervisor flag register group.
// Assumes the design files and the bound checker are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0] adr_i = '0;
	logic [3:0] sel_i = '0;
	logic [31:0] dat_i = '0, dat_o, lf = 32'h64d0ce01;
	logic ack_o, err_o, irq_o;
	logic [2:0] ev = '0;
	logic [12:0] lv = 13'h1000;
	logic [9:0] q[$];
	logic [9:0] e;
	logic [3:0] sel_w = 4'hf;
	int err_total = 0, checks = 0;
	always #20 clk_i = ~clk_i;
	supervisor_status_flags uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
		.dat_o, .ack_o, .err_o, .irq_o, .monitor_b_good_event_i(ev[2]),
		.monitor_a_good_event_i(ev[1]), .analog_supply_good_event_i(ev[0]),
		.sync_clock_valid_i(lv[12]), .thermal_shutdown_live_i(lv[11]),
		.thermal_warning_live_i(lv[10]), .input_overvoltage_live_i(lv[9]),
		.step_down_b_enabled_i(lv[8]), .step_down_b_good_live_i(lv[7]),
		.step_down_b_limit_live_i(lv[6]), .step_down_a_enabled_i(lv[5]),
		.step_down_a_good_live_i(lv[4]), .step_down_a_limit_live_i(lv[3]),
		.step_up_enabled_i(lv[2]), .step_up_good_live_i(lv[1]), .step_up_limit_live_i(lv[0]));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Entry: data compare flag, expected error, expected data
	task automatic bus(input logic w, input logic [7:0] ix, d, input logic [9:0] x);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i} <= {2'b11, w};
		sel_i <= sel_w;
		adr_i <= {ix, 2'b00};
		dat_i <= {24'h0, d};
		q.push_back(x);
		do @(negedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
		@(posedge clk_i);
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic rd(input logic [7:0] ix, d);
		bus(1'b0, ix, 8'h00, {2'b10, d});
	endtask
	task automatic pulse(input logic [2:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 3'b000;
		repeat (3) @(negedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 || err_o === 1'b1) begin
			e = q.pop_front();
			chk("err_o", {31'h0, err_o}, {31'h0, e[8]});
			if (e[9]) chk("dat_o", dat_o, {24'h0, e[7:0]});
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h24, 8'h00);
		rd(8'h2b, 8'h00);
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			@(posedge clk_i);
			lv <= lf[12:0];
			for (int r = 37; r < 40; r++) bus(1'b1, r[7:0], 8'hff, 10'h000);
			rd(8'h25, {4'h0, !lv[12], lv[11:9]});
			rd(8'h26, {lv[8:7], 1'b0, lv[6:4], 1'b0, lv[3]});
			rd(8'h27, {4'h0, lv[2:1], 1'b0, lv[0]});
		end
		for (int i = 0; i < 3; i++) begin
			pulse(3'b001 << i);
			chk("irq_o", {31'h0, irq_o}, 32'h1);
			rd(8'h24, 8'h01 << (2 * i));
			bus(1'b1, 8'h24, ~(8'h01 << (2 * i)), 10'h000);
			rd(8'h24, 8'h01 << (2 * i));
			bus(1'b1, 8'h24, 8'h15, 10'h000);
			rd(8'h24, 8'h00);
			@(negedge clk_i);
			chk("irq_o", {31'h0, irq_o}, 32'h0);
		end
		bus(1'b1, 8'h2b, 8'hff, 10'h000);
		rd(8'h2b, 8'h15);
		sel_w = 4'he;
		bus(1'b1, 8'h2b, 8'h00, 10'h000);
		sel_w = 4'hf;
		rd(8'h2b, 8'h15);
		pulse(3'b111);
		chk("irq_o", {31'h0, irq_o}, 32'h0);
		// Event high only in the cycle the clear is taken
		fork
			bus(1'b1, 8'h24, 8'hff, 10'h000);
			begin
				@(posedge clk_i);
				ev <= 3'b111;
				@(posedge clk_i);
				ev <= 3'b000;
			end
		join
		rd(8'h24, 8'h15);
		bus(1'b1, 8'h2b, 8'h00, 10'h000);
		@(negedge clk_i);
		chk("irq_o", {31'h0, irq_o}, 32'h1);
		bus(1'b1, 8'h24, 8'h15, 10'h000);
		rd(8'h24, 8'h00);
		bus(1'b0, 8'h30, 8'h00, 10'h100);
		@(negedge clk_i);
		chk("irq_o", {31'h0, irq_o}, 32'h0);
		chk("pending", q.size(), 32'h0);
		wrap_up();
	end
	initial begin
		repeat (4000) @(posedge clk_i);
		err_total++;
		wrap_up();
	end
endmodule
